// >>> crf_cpu_control_register_file.sv
// control, addressing and segment register set of the cpu core
//Function
// (RULE1) sign flag bit 11 follows the msb of each alu result
// (RULE2) overflow flag bit 9 set when result leaves signed range
// (RULE3) user flags bits 10, 6, 3 change only by instruction writes
// (RULE4) global interrupt enable bit 8 gates all maskable interrupts
// (RULE5) interrupt pushes status word then clears enable; return restores it
// (RULE6) enable change affects interrupt generation from the next instruction
// (RULE7) common-area select bits 5:4 give upper limit 03ff/1fff/3fff/7fff
// (RULE8) pointing set bits 2:0 select 8-byte set at 0200h plus 8n
// (RULE9) program counter advances by length or branches; overflow keeps code segment
// (RULE10) any reset source or interrupt loads the program counter from vector; on reset pc_reg loads 0000h, the output shows the vector one cycle
// (RULE11) local base low byte selects block at 0200h plus eight times byte
// (RULE12) local base high byte selects a 256-byte page in data segment
// (RULE13) special-bit accesses only reach offsets c0h to ffh of current page
// (RULE14) local base at offsets 02h/03h, undefined after reset
// (RULE15) stack pointer moves by word, bit 0 always zero; code clears bit 0 on the stack address only
// (RULE16) stack pointer at offset 00h, resets to ffffh
// (RULE17) pointing registers stored low byte even, high byte odd address
// (RULE18) byte local picks 1 of 8 bytes, word local 1 of 4 pairs
// (RULE19) segment registers keep bits 3:0 only, upper bits read zero
// (RULE20) code segment unmapped, changed only by far transfers, resets to 00h
// (RULE21) in 1mb mode interrupts push code segment too; return restores it
// (RULE22) table segment written by sfr access, resets 00h, no overflow carry
// (RULE23) status word clears to 0000h on every reset source
`timescale 1ns/1ps
`include "crf_defines.svh"
module crf_cpu_control_register_file #(
	parameter int DATA_W = 16
) (
	input wire logic i_clk,
	input wire logic i_srst,
	// other reset sources, each one-cycle pulses
	input wire logic i_break_instruction,
	input wire logic i_watchdog_overflow,
	input wire logic i_opcode_trap,
	input wire logic [15:0] i_reset_vector,
	// special-function byte access
	input wire logic i_sfr_wr,
	input wire logic [7:0] i_sfr_addr,
	input wire logic [7:0] i_sfr_wdata,
	output logic [7:0] o_sfr_rdata,
	// alu result flag update
	input wire logic i_alu_upd,
	input wire logic i_alu_word,
	input wire logic i_alu_arith,
	input wire logic [15:0] i_alu_a,
	input wire logic [15:0] i_alu_b,
	input wire logic [15:0] i_alu_res,
	// instruction boundary and program counter control
	input wire logic i_instr_done,
	input wire logic [2:0] i_instr_len,
	input wire logic i_branch,
	input wire logic [15:0] i_branch_target,
	// far transfers: jump, call, vector call, return
	input wire logic i_far_load,
	input wire logic [3:0] i_far_segment,
	// stack ops of calls, returns, pushes and pops
	input wire logic [1:0] i_sp_op,
	input wire logic [15:0] i_pop_data,
	// interrupt entry and return
	input wire logic i_irq_req,
	input wire logic [15:0] i_irq_vector,
	input wire logic i_return_from_interrupt,
	input wire logic [15:0] i_rti_psw,
	input wire logic [3:0] i_rti_cseg,
	input wire logic i_expanded_1mb,
	// special-bit and local register requests
	input wire logic [7:0] i_sba_offset,
	input wire logic [2:0] i_byte_local_sel,
	input wire logic [1:0] i_word_local_sel,
	// outputs
	output logic [15:0] o_processor_status_word,
	output logic [15:0] o_program_counter,
	output logic [15:0] o_system_stack_pointer,
	output logic [15:0] o_stack_addr,
	output logic o_push_valid,
	output logic [15:0] o_push_data,
	output logic o_irq_ack,
	output logic [3:0] o_code_segment_select,
	output logic [3:0] o_table_segment_select,
	output logic [3:0] o_data_segment_select,
	output logic [15:0] o_common_area_limit,
	output logic [15:0] o_pointing_set_addr,
	output logic [15:0] o_byte_local_addr,
	output logic [15:0] o_word_local_addr,
	output logic [15:0] o_sba_addr,
	output logic o_sba_hit,
	output logic o_int_allowed
);
	// ************************************************************
	// reset sources and state
	// ************************************************************
	logic any_reset;
	logic [15:0] psw_reg;
	logic [15:0] pc_reg;
	logic [15:0] ssp_reg;
	logic [15:0] lrb_reg;
	logic [3:0] cseg_reg;
	logic [3:0] tseg_reg;
	logic [3:0] dseg_reg;
	logic gie_eff_reg;
	logic [15:0] psw_next;
	crf_pkg::crf_state_e state_reg;
	crf_pkg::crf_state_e state_next;
	logic push_valid_next;
	logic [15:0] push_data_next;
	logic push_valid_reg;
	logic [15:0] push_data_reg;
	logic ovf;
	logic sign;

	// every reset source restarts the core registers except the local register base
	assign any_reset = i_srst | i_break_instruction | i_watchdog_overflow | i_opcode_trap;

	// ************************************************************
	// flag computation
	// ************************************************************
	// sign and signed overflow from operand and result signs
	always_comb begin
		if (i_alu_word) begin
			sign = i_alu_res[15]; // RULE1
			ovf = (i_alu_a[15] == i_alu_b[15]) && (i_alu_res[15] != i_alu_a[15]); // RULE2
		end else begin
			sign = i_alu_res[7]; // RULE1
			ovf = (i_alu_a[7] == i_alu_b[7]) && (i_alu_res[7] != i_alu_a[7]); // RULE2
		end
	end

	// next status word: sfr writes, alu flags, interrupt entry and return
	always_comb begin
		psw_next = psw_reg;
		if (i_sfr_wr && i_sfr_addr == `CRF_SFR_PSW_LO) begin
			psw_next[7:0] = i_sfr_wdata; // RULE3
		end
		if (i_sfr_wr && i_sfr_addr == `CRF_SFR_PSW_HI) begin
			psw_next[15:8] = i_sfr_wdata; // RULE3
		end
		if (i_alu_upd) begin
			psw_next[`CRF_BIT_SIGN] = sign; // RULE1
			if (i_alu_arith) begin
				psw_next[`CRF_BIT_OVF] = ovf; // RULE2
			end
		end
		if (i_return_from_interrupt) begin
			psw_next = i_rti_psw; // RULE5
		end
		if (state_reg == crf_pkg::CRF_PUSH_PSW) begin
			psw_next[`CRF_BIT_GIE] = 1'b0; // RULE5
		end
	end

	// status word register
	always_ff @(posedge i_clk) begin
		if (any_reset) begin
			psw_reg <= `CRF_PSW_RST; // RULE23
		end else begin
			psw_reg <= psw_next;
		end
	end

	// enable seen by interrupt generation, updated at instruction boundaries
	always_ff @(posedge i_clk) begin
		if (any_reset) begin
			gie_eff_reg <= 1'b0;
		end else if (state_reg == crf_pkg::CRF_PUSH_PSW) begin
			gie_eff_reg <= 1'b0;
		end else if (i_instr_done) begin
			gie_eff_reg <= psw_next[`CRF_BIT_GIE]; // RULE6
		end
	end

	assign o_int_allowed = gie_eff_reg & (state_reg == crf_pkg::CRF_IDLE); // RULE4

	// ************************************************************
	// interrupt entry sequence
	// ************************************************************
	// idle -> push status -> push code segment (1mb) -> vector
	always_comb begin
		state_next = state_reg;
		push_valid_next = 1'b0;
		push_data_next = 16'h0000;
		case (state_reg)
			crf_pkg::CRF_IDLE: begin
				if (i_irq_req && o_int_allowed && i_instr_done) begin
					state_next = crf_pkg::CRF_PUSH_PSW;
				end
			end
			crf_pkg::CRF_PUSH_PSW: begin
				push_valid_next = 1'b1;
				push_data_next = psw_reg; // RULE5
				state_next = i_expanded_1mb ? crf_pkg::CRF_PUSH_CSEG : crf_pkg::CRF_VECTOR;
			end
			crf_pkg::CRF_PUSH_CSEG: begin
				push_valid_next = 1'b1;
				push_data_next = {12'h000, cseg_reg}; // RULE21
				state_next = crf_pkg::CRF_VECTOR;
			end
			crf_pkg::CRF_VECTOR: begin
				state_next = crf_pkg::CRF_IDLE;
			end
			default: begin
				state_next = crf_pkg::CRF_IDLE;
			end
		endcase
	end

	// sequencer state and push strobe
	always_ff @(posedge i_clk) begin
		if (any_reset) begin
			state_reg <= crf_pkg::CRF_IDLE;
			push_valid_reg <= 1'b0;
			push_data_reg <= 16'h0000;
		end else begin
			state_reg <= state_next;
			push_valid_reg <= push_valid_next;
			push_data_reg <= push_data_next;
		end
	end

	assign o_push_valid = push_valid_reg;
	assign o_push_data = push_data_reg;
	assign o_irq_ack = (state_reg == crf_pkg::CRF_VECTOR);

	// ************************************************************
	// program counter
	// ************************************************************
	// vector loads win over branches; increment wraps in 16 bits
	always_ff @(posedge i_clk) begin
		if (any_reset) begin
			pc_reg <= 16'h0000; // RULE10
		end else if (state_reg == crf_pkg::CRF_VECTOR) begin
			pc_reg <= i_irq_vector; // RULE10
		end else if (i_branch) begin
			pc_reg <= i_branch_target; // RULE9
		end else if (i_instr_done) begin
			pc_reg <= pc_reg + {13'h0000, i_instr_len}; // RULE9
		end
	end

	// vector fetch after reset release: the output shows the reset vector until the first edge, pc_reg holds 0000h
	logic rst_d_reg;
	always_ff @(posedge i_clk) begin
		rst_d_reg <= any_reset;
	end

	assign o_program_counter = rst_d_reg ? i_reset_vector : pc_reg; // RULE10

	// ************************************************************
	// stack pointer
	// ************************************************************
	// word moves only; bit 0 is forced to zero on the stack address
	always_ff @(posedge i_clk) begin
		if (any_reset) begin
			ssp_reg <= `CRF_SSP_RST; // RULE16
		end else if (push_valid_next || i_sp_op == crf_pkg::CRF_SP_PUSH) begin
			ssp_reg <= ssp_reg - 16'h0002; // RULE15
		end else if (i_sp_op == crf_pkg::CRF_SP_POP) begin
			ssp_reg <= ssp_reg + 16'h0002; // RULE15
		end else if (i_sfr_wr && i_sfr_addr == `CRF_SFR_SSP_LO) begin
			ssp_reg[7:0] <= i_sfr_wdata; // RULE16
		end else if (i_sfr_wr && i_sfr_addr == `CRF_SFR_SSP_HI) begin
			ssp_reg[15:8] <= i_sfr_wdata; // RULE16
		end
	end

	assign o_system_stack_pointer = ssp_reg;
	assign o_stack_addr = {ssp_reg[15:1], 1'b0}; // RULE15

	// ************************************************************
	// local register base, no reset value
	// ************************************************************
	always_ff @(posedge i_clk) begin
		if (i_sfr_wr && i_sfr_addr == `CRF_SFR_LRB_LO) begin
			lrb_reg[7:0] <= i_sfr_wdata; // RULE14
		end
		if (i_sfr_wr && i_sfr_addr == `CRF_SFR_LRB_HI) begin
			lrb_reg[15:8] <= i_sfr_wdata; // RULE14
		end
	end

	// ************************************************************
	// segment registers
	// ************************************************************
	// code segment: only far transfers, interrupt return
	always_ff @(posedge i_clk) begin
		if (any_reset) begin
			cseg_reg <= `CRF_SEG_RST; // RULE20
		end else if (i_return_from_interrupt && i_expanded_1mb) begin
			cseg_reg <= i_rti_cseg; // RULE21
		end else if (i_far_load) begin
			cseg_reg <= i_far_segment; // RULE20
		end
	end

	// table and data segments: sfr writes keep the low nibble
	always_ff @(posedge i_clk) begin
		if (any_reset) begin
			tseg_reg <= `CRF_SEG_RST; // RULE22
		end else if (i_sfr_wr && i_sfr_addr == `CRF_SFR_TSEG) begin
			tseg_reg <= i_sfr_wdata[3:0]; // RULE19
		end
	end

	always_ff @(posedge i_clk) begin
		if (any_reset) begin
			dseg_reg <= `CRF_SEG_RST;
		end else if (i_sfr_wr && i_sfr_addr == `CRF_SFR_DSEG) begin
			dseg_reg <= i_sfr_wdata[3:0]; // RULE19
		end
	end

	assign o_code_segment_select = cseg_reg;
	assign o_table_segment_select = tseg_reg;
	assign o_data_segment_select = dseg_reg;
	assign o_processor_status_word = psw_reg;

	// ************************************************************
	// sfr read mux
	// ************************************************************
	always_comb begin
		case (i_sfr_addr)
			`CRF_SFR_SSP_LO: o_sfr_rdata = ssp_reg[7:0];
			`CRF_SFR_SSP_HI: o_sfr_rdata = ssp_reg[15:8];
			`CRF_SFR_LRB_LO: o_sfr_rdata = lrb_reg[7:0];
			`CRF_SFR_LRB_HI: o_sfr_rdata = lrb_reg[15:8];
			`CRF_SFR_PSW_LO: o_sfr_rdata = psw_reg[7:0];
			`CRF_SFR_PSW_HI: o_sfr_rdata = psw_reg[15:8];
			`CRF_SFR_TSEG: o_sfr_rdata = {4'h0, tseg_reg}; // RULE19
			`CRF_SFR_DSEG: o_sfr_rdata = {4'h0, dseg_reg}; // RULE19
			default: o_sfr_rdata = 8'h00;
		endcase
	end

	// ************************************************************
	// address generation
	// ************************************************************
	// common-area limit from bits 5:4
	always_comb begin
		case (psw_reg[`CRF_BIT_CAS_LO +: 2])
			2'b00: o_common_area_limit = `CRF_CAS_LIM0; // RULE7
			2'b01: o_common_area_limit = `CRF_CAS_LIM1; // RULE7
			2'b10: o_common_area_limit = `CRF_CAS_LIM2; // RULE7
			default: o_common_area_limit = `CRF_CAS_LIM3; // RULE7
		endcase
	end

	// pointing set base; index_one, index_two, data_pointer, user_stack_pointer
	// follow at +0, +2, +4, +6 with low byte at the even address
	assign o_pointing_set_addr = `CRF_RAM_BASE + {10'h000, psw_reg[`CRF_BIT_PSS_LO +: 3], 3'b000}; // RULE8 RULE17

	// local register block and element
	logic [15:0] local_block;
	assign local_block = `CRF_RAM_BASE + {5'h00, lrb_reg[7:0], 3'b000}; // RULE11
	assign o_byte_local_addr = local_block + {13'h0000, i_byte_local_sel}; // RULE18
	assign o_word_local_addr = local_block + {13'h0000, i_word_local_sel, 1'b0}; // RULE18

	// special-bit area on the current page
	assign o_sba_hit = (i_sba_offset >= `CRF_SBA_BASE); // RULE13
	assign o_sba_addr = {lrb_reg[15:8], 2'b11, i_sba_offset[5:0]}; // RULE12 RULE13
endmodule

// >>> crf_ctrl_props.sv
// port-level assertions for the control register file
`timescale 1ns/1ps
`include "crf_defines.svh"
module crf_ctrl_props (
	input logic i_clk,
	input logic i_srst,
	input logic i_break_instruction,
	input logic i_watchdog_overflow,
	input logic i_opcode_trap,
	input logic i_sfr_wr,
	input logic [7:0] i_sfr_addr,
	input logic [7:0] i_sfr_wdata,
	input logic i_alu_upd,
	input logic i_alu_word,
	input logic [15:0] i_alu_res,
	input logic i_return_from_interrupt,
	input logic [1:0] i_sp_op,
	input logic [15:0] i_irq_vector,
	input logic [7:0] i_sba_offset,
	input logic [15:0] o_processor_status_word,
	input logic [15:0] o_system_stack_pointer,
	input logic [15:0] o_stack_addr,
	input logic o_push_valid,
	input logic o_irq_ack,
	input logic [3:0] o_table_segment_select,
	input logic [15:0] o_common_area_limit,
	input logic [15:0] o_pointing_set_addr,
	input logic o_sba_hit,
	input logic o_int_allowed,
	input logic [15:0] o_program_counter
);
	// any reset source, and the result msb the sign flag must follow
	wire rst_any = i_srst | i_break_instruction | i_watchdog_overflow | i_opcode_trap;
	wire msb = i_alu_word ? i_alu_res[15] : i_alu_res[7];
	wire [15:0] processor_status_word = o_processor_status_word;
	// ****************
	// assertions
	// ****************
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_srst);
	chk_reset_values: assert property (disable iff (1'b0) rst_any |=>
		processor_status_word == `CRF_PSW_RST && o_system_stack_pointer == `CRF_SSP_RST)
		else $error("reset values wrong");
	chk_sign_flag: assert property (
		i_alu_upd && !rst_any && !i_sfr_wr && !i_return_from_interrupt |=>
		processor_status_word[`CRF_BIT_SIGN] == $past(msb)) else $error("sign flag wrong");
	chk_tseg_write: assert property (
		i_sfr_wr && i_sfr_addr == `CRF_SFR_TSEG && !rst_any |=>
		{4'h0, o_table_segment_select} == ($past(i_sfr_wdata) & 8'h0f))
		else $error("table segment write wrong");
	chk_stack_even: assert property (
		o_stack_addr == {o_system_stack_pointer[15:1], 1'b0}) else $error("stack lsb set");
	chk_stack_step: assert property (
		i_sp_op != 2'b00 && !rst_any && !i_sfr_wr |=> o_system_stack_pointer ==
		$past(o_system_stack_pointer) + ($past(i_sp_op) == 2'b11 ? 16'h0002 : 16'hfffe))
		else $error("stack step wrong");
	chk_enable_gate: assert property (
		$rose(o_int_allowed) |-> processor_status_word[`CRF_BIT_GIE])
		else $error("interrupt allowed while disabled");
	chk_common_limit: assert property (
		o_common_area_limit == (processor_status_word[5] ? (processor_status_word[4] ? `CRF_CAS_LIM3 : `CRF_CAS_LIM2) :
		(processor_status_word[4] ? `CRF_CAS_LIM1 : `CRF_CAS_LIM0))) else $error("common limit wrong");
	chk_pointing_set: assert property (
		o_pointing_set_addr == `CRF_RAM_BASE + {10'h0, processor_status_word[2:0], 3'b000})
		else $error("pointing set address wrong");
	chk_sba_window: assert property (
		o_sba_hit == (i_sba_offset >= `CRF_SBA_BASE)) else $error("bit area window wrong");
	chk_irq_vector: assert property (
		o_irq_ack |-> !processor_status_word[`CRF_BIT_GIE] ##1 o_program_counter == $past(i_irq_vector))
		else $error("interrupt vector entry wrong");
	// main scenarios reached
	cov_irq: cover property (o_irq_ack);
	cov_two_push: cover property (o_push_valid ##1 o_push_valid);
	cov_pop: cover property (i_sp_op == 2'b11);
endmodule

// >>> crf_defines.svh
// offsets, field positions, reset values and address constants of the control register file
`ifndef CRF_DEFINES_SVH
`define CRF_DEFINES_SVH
// special-function offsets
`define CRF_SFR_SSP_LO 8'h00
`define CRF_SFR_SSP_HI 8'h01
`define CRF_SFR_LRB_LO 8'h02
`define CRF_SFR_LRB_HI 8'h03
`define CRF_SFR_PSW_LO 8'h04
`define CRF_SFR_PSW_HI 8'h05
`define CRF_SFR_TSEG 8'h06
`define CRF_SFR_DSEG 8'h07
// status word bit positions
`define CRF_BIT_SIGN 11
`define CRF_BIT_USER2 10
`define CRF_BIT_OVF 9
`define CRF_BIT_GIE 8
`define CRF_BIT_USER1 6
`define CRF_BIT_USER0 3
`define CRF_BIT_CAS_LO 4
`define CRF_BIT_PSS_LO 0
// reset values
`define CRF_PSW_RST 16'h0000
`define CRF_SSP_RST 16'hffff
`define CRF_SEG_RST 4'h0
// address constants
`define CRF_RAM_BASE 16'h0200
`define CRF_SBA_BASE 8'hc0
`define CRF_CAS_LIM0 16'h03ff
`define CRF_CAS_LIM1 16'h1fff
`define CRF_CAS_LIM2 16'h3fff
`define CRF_CAS_LIM3 16'h7fff
`endif

// >>> crf_pkg.sv
// types of the control register file
package crf_pkg;
	// stack pointer motion
	typedef enum logic [1:0] {
		CRF_SP_HOLD = 2'b00,
		CRF_SP_PUSH = 2'b01,
		CRF_SP_POP = 2'b11
	} crf_sp_e;
	// interrupt sequencing states, gray along the 1mb push path
	typedef enum logic [1:0] {
		CRF_IDLE = 2'b00,
		CRF_PUSH_PSW = 2'b01,
		CRF_PUSH_CSEG = 2'b11,
		CRF_VECTOR = 2'b10
	} crf_state_e;
endpackage

// >>> test_cpu_control_register_file.sv
// self-checking testbench of the control register file
`timescale 1ns/1ps
module test_cpu_control_register_file;
	// ****************
	// stimulus and observed ports
	// ****************
	logic i_clk = 1'b0, i_srst = 1'b1, i_break_instruction = 1'b0, i_watchdog_overflow = 1'b0;
	logic i_opcode_trap = 1'b0, i_sfr_wr = 1'b0, i_alu_upd = 1'b0, i_alu_word = 1'b0;
	logic i_alu_arith = 1'b0, i_instr_done = 1'b0, i_branch = 1'b0, i_far_load = 1'b0;
	logic i_irq_req = 1'b0, i_expanded_1mb = 1'b0, i_return_from_interrupt = 1'b0, ack;
	logic [15:0] i_reset_vector = 16'h1234, i_alu_a = 16'h0, i_alu_b = 16'h0, i_alu_res = 16'h0;
	logic [15:0] i_branch_target = 16'h0, i_pop_data = 16'h0, i_irq_vector = 16'h0abc, pd;
	logic [15:0] i_rti_psw = 16'h0100;
	logic [7:0] i_sfr_addr = 8'h0, i_sfr_wdata = 8'h0, i_sba_offset = 8'h0, o_sfr_rdata;
	logic [3:0] i_far_segment = 4'h5, i_rti_cseg = 4'h9;
	logic [2:0] i_instr_len = 3'h3, i_byte_local_sel = 3'h0;
	logic [1:0] i_word_local_sel = 2'h0, i_sp_op = 2'h0;
	logic [15:0] o_processor_status_word, o_program_counter, o_system_stack_pointer;
	logic [15:0] o_stack_addr, o_push_data, o_common_area_limit, o_pointing_set_addr;
	logic [15:0] o_byte_local_addr, o_word_local_addr, o_sba_addr;
	logic [3:0] o_code_segment_select, o_table_segment_select, o_data_segment_select;
	logic o_push_valid, o_irq_ack, o_sba_hit, o_int_allowed;
	logic [15:0] lim [4] = '{16'h03ff, 16'h1fff, 16'h3fff, 16'h7fff};
	int err_total = 0, check_count = 0, np = 0;
	// 250 mhz clock
	always #2 i_clk = ~i_clk;
	crf_cpu_control_register_file dut (.i_clk, .i_srst, .i_break_instruction,
		.i_watchdog_overflow, .i_opcode_trap, .i_reset_vector, .i_sfr_wr, .i_sfr_addr,
		.i_sfr_wdata, .o_sfr_rdata, .i_alu_upd, .i_alu_word, .i_alu_arith, .i_alu_a, .i_alu_b,
		.i_alu_res, .i_instr_done, .i_instr_len, .i_branch, .i_branch_target, .i_far_load,
		.i_far_segment, .i_sp_op, .i_pop_data, .i_irq_req, .i_irq_vector,
		.i_return_from_interrupt, .i_rti_psw, .i_rti_cseg, .i_expanded_1mb, .i_sba_offset,
		.i_byte_local_sel, .i_word_local_sel, .o_processor_status_word, .o_program_counter,
		.o_system_stack_pointer, .o_stack_addr, .o_push_valid, .o_push_data, .o_irq_ack,
		.o_code_segment_select, .o_table_segment_select, .o_data_segment_select,
		.o_common_area_limit, .o_pointing_set_addr, .o_byte_local_addr, .o_word_local_addr,
		.o_sba_addr, .o_sba_hit, .o_int_allowed);
	// compare, byte access and flag update helpers
	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
		check_count++;
		if (s !== e) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge i_clk);
		i_sfr_wr = 1'b1;
		i_sfr_addr = a;
		i_sfr_wdata = d;
		@(negedge i_clk);
		i_sfr_wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge i_clk);
		i_sfr_addr = a;
		#1 chk("sfr_rdata", {8'h0, o_sfr_rdata}, {8'h0, e});
	endtask
	task automatic alu(input logic w, input logic ar, input logic [15:0] r, input logic [15:0] e);
		@(negedge i_clk);
		i_alu_upd = 1'b1;
		i_alu_word = w;
		i_alu_arith = ar;
		i_alu_a = r[15] ? 16'h7fff : 16'h007f;
		i_alu_b = 16'h0001;
		i_alu_res = r;
		@(negedge i_clk);
		i_alu_upd = 1'b0;
		chk("psw", o_processor_status_word, e);
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// hang guard, far beyond the hundred or so cycles the tests need
	initial begin
		#20000;
		err_total++;
		finish_test();
	end
	// main sequence
	initial begin
		repeat (20) @(negedge i_clk);
		i_srst = 1'b0;
		#1 chk("pc", o_program_counter, 16'h1234);
		rd(8'h00, 8'hff);
		rd(8'h01, 8'hff);
		rd(8'h05, 8'h00);
		rd(8'h06, 8'h00);
		rd(8'h40, 8'h00);
		chk("cseg", {12'h0, o_code_segment_select}, 16'h0);
		$display("test reset done");
		wr(8'h02, 8'h34);
		wr(8'h03, 8'h12);
		rd(8'h02, 8'h34);
		for (int k = 0; k < 8; k++) begin
			@(negedge i_clk);
			i_byte_local_sel = k[2:0];
			i_word_local_sel = k[1:0];
			i_sba_offset = {k[0], 7'h45};
			#1 chk("byte_local", o_byte_local_addr, 16'h03a0 + k[15:0]);
			chk("word_local", o_word_local_addr, 16'h03a0 + {k[14:0], 1'b0} & 16'hfff7);
			chk("sba", o_sba_addr, 16'h12c5);
			chk("sba_hit", {15'h0, o_sba_hit}, {15'h0, k[0]});
		end
		wr(8'h06, 8'h0f);
		rd(8'h06, 8'h0f);
		wr(8'h07, 8'h05);
		chk("dseg", {12'h0, o_data_segment_select}, 16'h5);
		$display("test addressing done");
		for (int n = 0; n < 8; n++) begin
			wr(8'h04, {2'b00, n[1:0], 1'b0, n[2:0]});
			chk("pset", o_pointing_set_addr, 16'h0200 + {n[12:0], 3'b000});
			chk("limit", o_common_area_limit, lim[n[1:0]]);
		end
		wr(8'h04, 8'h48);
		wr(8'h05, 8'h04);
		alu(1'b1, 1'b1, 16'h8000, 16'h0e48);
		alu(1'b0, 1'b1, 16'h0002, 16'h0448);
		alu(1'b0, 1'b1, 16'h0080, 16'h0e48);
		alu(1'b0, 1'b0, 16'h0000, 16'h0648);
		$display("test flags done");
		@(negedge i_clk);
		i_branch = 1'b1;
		i_branch_target = 16'hfffe;
		@(negedge i_clk);
		i_branch = 1'b0;
		i_instr_done = 1'b1;
		@(negedge i_clk);
		i_instr_done = 1'b0;
		i_far_load = 1'b1;
		chk("pc", o_program_counter, 16'h0001);
		chk("cseg", {12'h0, o_code_segment_select}, 16'h0);
		@(negedge i_clk);
		i_far_load = 1'b0;
		i_sp_op = 2'b01;
		chk("cseg", {12'h0, o_code_segment_select}, 16'h5);
		@(negedge i_clk);
		i_sp_op = 2'b11;
		chk("stack", o_stack_addr, 16'hfffc);
		@(negedge i_clk);
		i_sp_op = 2'b00;
		chk("ssp", o_system_stack_pointer, 16'hffff);
		wr(8'h00, 8'h10);
		wr(8'h01, 8'h20);
		chk("ssp", o_system_stack_pointer, 16'h2010);
		$display("test pc and stack done");
		wr(8'h05, 8'h01);
		chk("allowed", {15'h0, o_int_allowed}, 16'h0);
		i_instr_done = 1'b1;
		@(negedge i_clk);
		i_instr_done = 1'b0;
		chk("allowed", {15'h0, o_int_allowed}, 16'h1);
		i_expanded_1mb = 1'b1;
		i_irq_req = 1'b1;
		i_instr_done = 1'b1;
		ack = 1'b0;
		for (int t = 0; t < 20 && !ack; t++) begin
			@(negedge i_clk);
			i_instr_done = 1'b0;
			if (o_push_valid === 1'b1) begin
				if (np == 0)
					pd = o_push_data;
				else
					chk("pushed_cseg", o_push_data, 16'h0005);
				np++;
			end
			ack = (o_irq_ack === 1'b1);
		end
		i_irq_req = 1'b0;
		chk("irq_ack", {15'h0, ack}, 16'h1);
		@(negedge i_clk);
		chk("pc", o_program_counter, 16'h0abc);
		chk("psw", o_processor_status_word, 16'h0048);
		chk("pushed_psw", pd, 16'h0148);
		chk("pushes", np[15:0], 16'h2);
		chk("ssp", o_system_stack_pointer, 16'h200c);
		i_return_from_interrupt = 1'b1;
		@(negedge i_clk);
		i_return_from_interrupt = 1'b0;
		chk("psw", o_processor_status_word, 16'h0100);
		chk("cseg", {12'h0, o_code_segment_select}, 16'h9);
		$display("test interrupt done");
		for (int s = 0; s < 3; s++) begin
			wr(8'h00, 8'h00);
			wr(8'h04, 8'h5a);
			@(negedge i_clk);
			{i_opcode_trap, i_watchdog_overflow, i_break_instruction} = 3'b001 << s;
			@(negedge i_clk);
			{i_opcode_trap, i_watchdog_overflow, i_break_instruction} = 3'b000;
			chk("pc", o_program_counter, 16'h1234);
			chk("psw", o_processor_status_word, 16'h0000);
			chk("ssp", o_system_stack_pointer, 16'hffff);
			chk("cseg", {12'h0, o_code_segment_select}, 16'h0);
		end
		$display("test reset sources done");
		finish_test();
	end
endmodule
bind crf_cpu_control_register_file crf_ctrl_props u_props (.i_clk, .i_srst,
	.i_break_instruction, .i_watchdog_overflow, .i_opcode_trap, .i_sfr_wr, .i_sfr_addr,
	.i_sfr_wdata, .i_alu_upd, .i_alu_word, .i_alu_res, .i_return_from_interrupt, .i_sp_op,
	.i_irq_vector, .i_sba_offset, .o_processor_status_word, .o_system_stack_pointer,
	.o_stack_addr, .o_push_valid, .o_irq_ack, .o_table_segment_select, .o_common_area_limit,
	.o_pointing_set_addr, .o_sba_hit, .o_int_allowed, .o_program_counter);
